// File: logic/lcdpc_top.sv
// Purpose: Drive stage level selection and power supply control settings.
// Assumes: Command writes are single-cycle strobes synchronous to clk.
// Notes: Settings are write-only; invalid decoder codes select the regulated level.

module lcdpc_top
   import lcdpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic master_sel,
   input lcdpc_cmd_t cmd,
   input wire logic frame_start,
   input wire logic line_step,
   input wire logic [LCDPC_NSEG-1:0][2:0] seg_code,
   input wire logic [LCDPC_NCOM-1:0][1:0] com_code,
   output lcdpc_seg_lvl_t [LCDPC_NSEG-1:0] segment_output,
   output lcdpc_com_lvl_t [LCDPC_NCOM-1:0] common_output,
   output lcdpc_supply_t supply,
   output logic [7:0] active_com
);
   logic [LCDPC_SUP_W-1:0] supply_enable_control_reg; // Stored power control bits
   logic [LCDPC_SUP_W-1:0] supply_enable_control_next;
   logic [LCDPC_CON_W-1:0] contrast_step_reg; // Stored contrast step
   logic [LCDPC_CON_W-1:0] contrast_step_next;
   logic [LCDPC_RNG_W-1:0] drive_voltage_range_reg; // Stored range field
   logic [LCDPC_RNG_W-1:0] drive_voltage_range_next;
   logic scan_reverse_reg; // Common scan direction
   logic scan_reverse_next;
   lcdpc_supply_t supply_reg; // Registered supply outputs
   lcdpc_supply_t supply_next;
   logic is_master; // Master operation from select pin

   // Master when select pin high
   assign is_master = master_sel;

   // Settings write decode
   always_comb
   begin
      supply_enable_control_next = supply_enable_control_reg;
      contrast_step_next = contrast_step_reg;
      drive_voltage_range_next = drive_voltage_range_reg;
      scan_reverse_next = scan_reverse_reg;
      if (cmd.wr)
      begin
         case (cmd.sel)
            LCDPC_SEL_SUPPLY: supply_enable_control_next = cmd.data[LCDPC_SUP_W-1:0];
            LCDPC_SEL_CONTRAST: contrast_step_next = cmd.data;
            LCDPC_SEL_RANGE: drive_voltage_range_next = cmd.data[LCDPC_RNG_W-1:0];
            LCDPC_SEL_SCAN: scan_reverse_next = cmd.data[LCDPC_SCAN_DIR_BIT];
            default: scan_reverse_next = scan_reverse_reg;
         endcase
      end
   end

   // Settings registers with reset values
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         supply_enable_control_reg <= LCDPC_SUP_RST;
         contrast_step_reg <= LCDPC_CON_RST;
         drive_voltage_range_reg <= LCDPC_RNG_RST;
         scan_reverse_reg <= LCDPC_SCAN_RST;
      end
      else
      begin
         supply_enable_control_reg <= supply_enable_control_next;
         contrast_step_reg <= contrast_step_next;
         drive_voltage_range_reg <= drive_voltage_range_next;
         scan_reverse_reg <= scan_reverse_next;
      end
   end

   // Supply enables gated by master operation
   always_comb
   begin
      supply_next.pump_en = is_master & supply_enable_control_reg[LCDPC_SUP_PUMP_BIT];
      supply_next.regulator_en = is_master & supply_enable_control_reg[LCDPC_SUP_REG_BIT];
      supply_next.level_divider_en = is_master & supply_enable_control_reg[LCDPC_SUP_DIV_BIT];
      supply_next.pump_factor = supply_enable_control_reg[LCDPC_SUP_FAC_HI:LCDPC_SUP_FAC_LO];
      supply_next.contrast_step = contrast_step_reg;
      supply_next.drive_voltage_range = drive_voltage_range_reg;
   end

   // Supply output register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         supply_reg <= '0;
      end
      else
      begin
         supply_reg <= supply_next;
      end
   end

   assign supply = supply_reg;

   // Per-output level selection
   genvar gi;
   generate
      for (gi = 0; gi < LCDPC_NSEG; gi++)
      begin : g_seg
         lcdpc_seg_lvl_t lvl_reg; // Registered segment level
         lcdpc_seg_lvl_t lvl_next;
         // Decoder code to segment level
         always_comb
         begin
            case (seg_code[gi])
               3'h0: lvl_next = LCDPC_SEG_V2;
               3'h1: lvl_next = LCDPC_SEG_V1;
               3'h3: lvl_next = LCDPC_SEG_MV1;
               3'h4: lvl_next = LCDPC_SEG_MV2;
               default: lvl_next = LCDPC_SEG_VREG;
            endcase
         end
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               lvl_reg <= LCDPC_SEG_VREG;
            end
            else
            begin
               lvl_reg <= lvl_next;
            end
         end
         assign segment_output[gi] = lvl_reg;
      end
      for (gi = 0; gi < LCDPC_NCOM; gi++)
      begin : g_com
         lcdpc_com_lvl_t lvl_reg; // Registered common level
         lcdpc_com_lvl_t lvl_next;
         // Reverse scan mirrors the code onto the output order
         always_comb
         begin
            case (scan_reverse_reg ? com_code[LCDPC_NCOM-1-gi] : com_code[gi])
               2'h0: lvl_next = LCDPC_COM_V3;
               2'h2: lvl_next = LCDPC_COM_MV3;
               default: lvl_next = LCDPC_COM_VREG;
            endcase
         end
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               lvl_reg <= LCDPC_COM_VREG;
            end
            else
            begin
               lvl_reg <= lvl_next;
            end
         end
         assign common_output[gi] = lvl_reg;
      end
   endgenerate

   // Common scan position
   lcdpc_com_scan u_scan
   (
      .clk(clk),
      .rst(rst),
      .reverse(scan_reverse_reg),
      .frame_start(frame_start),
      .line_step(line_step),
      .active_com(active_com)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Slave operation keeps all enables off
   slave_off_a: assert property ($past(!master_sel) |-> !supply.pump_en &&
      !supply.regulator_en && !supply.level_divider_en)
      else $error("supply enabled in slave operation");
   // Pump enable follows written bit in master
   pump_write_a: assert property (cmd.wr && cmd.sel == LCDPC_SEL_SUPPLY && master_sel
      ##1 master_sel |=> supply.pump_en == $past(cmd.data[LCDPC_SUP_PUMP_BIT], 2))
      else $error("pump enable does not follow write");
   // Divider enable follows written bit in master
   div_write_a: assert property (cmd.wr && cmd.sel == LCDPC_SEL_SUPPLY
      ##1 master_sel |=> supply.level_divider_en == $past(cmd.data[LCDPC_SUP_DIV_BIT], 2))
      else $error("divider enable does not follow write");
   // Factor follows D4:D3
   factor_write_a: assert property (cmd.wr && cmd.sel == LCDPC_SEL_SUPPLY
      |-> ##2 supply.pump_factor == $past(cmd.data[LCDPC_SUP_FAC_HI:LCDPC_SUP_FAC_LO], 2))
      else $error("pump factor mismatch");
   // Contrast step written reaches output
   contrast_write_a: assert property (cmd.wr && cmd.sel == LCDPC_SEL_CONTRAST
      |-> ##2 supply.contrast_step == $past(cmd.data, 2))
      else $error("contrast step mismatch");
   // Range written reaches output
   range_write_a: assert property (cmd.wr && cmd.sel == LCDPC_SEL_RANGE
      |-> ##2 supply.drive_voltage_range == $past(cmd.data[1:0], 2))
      else $error("range mismatch");
   // Contrast holds without a contrast write; the output trails a write by two edges
   contrast_hold_a: assert property (!(cmd.wr && cmd.sel == LCDPC_SEL_CONTRAST) [*3]
      |-> $stable(supply.contrast_step))
      else $error("contrast changed without write");
   // Segment level matches decoder code
   seg_level_a: assert property (seg_code[0] == 3'h4 |=> segment_output[0] == LCDPC_SEG_MV2)
      else $error("segment level mismatch");
   // Common mapping honours scan direction
   com_level_a: assert property (scan_reverse_reg && com_code[LCDPC_NCOM-1] == 2'h2
      |=> common_output[0] == LCDPC_COM_MV3)
      else $error("common level mismatch");
   // Normal scan steps up by one
   scan_step_a: assert property (!scan_reverse_reg && line_step && !frame_start
      && active_com != LCDPC_COM_LAST |=> active_com == $past(active_com) + 8'h01)
      else $error("scan step wrong");
endmodule : lcdpc_top

// File: logic/lcdpc_pkg.sv
// Purpose: Shared constants and types for the LCD drive and power control block.
// Assumes: Settings arrive as decoded command writes from the command interface.
// Notes: All settings are write-only; the block drives levels and supply enables.
package lcdpc_pkg;
   // Command write target selector codes
   localparam logic [1:0] LCDPC_SEL_SUPPLY = 2'h0;
   localparam logic [1:0] LCDPC_SEL_CONTRAST = 2'h1;
   localparam logic [1:0] LCDPC_SEL_RANGE = 2'h2;
   localparam logic [1:0] LCDPC_SEL_SCAN = 2'h3;
   // Field positions inside the supply enable control and scan direction settings
   localparam int LCDPC_SUP_DIV_BIT = 0;
   localparam int LCDPC_SUP_REG_BIT = 1;
   localparam int LCDPC_SUP_PUMP_BIT = 2;
   localparam int LCDPC_SUP_FAC_LO = 3;
   localparam int LCDPC_SUP_FAC_HI = 4;
   localparam int LCDPC_SCAN_DIR_BIT = 0;
   // Widths and reset values
   localparam int LCDPC_SUP_W = 5;
   localparam int LCDPC_CON_W = 7;
   localparam int LCDPC_RNG_W = 2;
   localparam logic [4:0] LCDPC_SUP_RST = 5'h00;
   localparam logic [6:0] LCDPC_CON_RST = 7'h00;
   localparam logic [1:0] LCDPC_RNG_RST = 2'h0;
   localparam logic LCDPC_SCAN_RST = 1'b0;
   // Pump factor codes
   localparam logic [1:0] LCDPC_FAC_TRIPLE = 2'h3;
   localparam logic [1:0] LCDPC_FAC_DOUBLE = 2'h2;
   localparam logic [1:0] LCDPC_FAC_NONE = 2'h1;
   // Range codes; code 01 has no defined range
   localparam logic [1:0] LCDPC_RNG_LOW = 2'h0;
   localparam logic [1:0] LCDPC_RNG_MID = 2'h2;
   localparam logic [1:0] LCDPC_RNG_HIGH = 2'h3;
   // Driver counts
   localparam int LCDPC_NSEG = 160;
   localparam int LCDPC_NCOM = 132;
   localparam logic [7:0] LCDPC_COM_LAST = 8'h83;
   localparam logic [7:0] LCDPC_COM_FIRST = 8'h00;
   // Minimum regulator-to-divider spacing expected from the host, in ms
   localparam int LCDPC_REG_TO_DIV_MS = 100;

   // Segment level selection
   typedef enum logic [2:0]
   {
      LCDPC_SEG_V2 = 3'h0,
      LCDPC_SEG_V1 = 3'h1,
      LCDPC_SEG_VREG = 3'h2,
      LCDPC_SEG_MV1 = 3'h3,
      LCDPC_SEG_MV2 = 3'h4
   } lcdpc_seg_lvl_t;

   // Common level selection
   typedef enum logic [1:0]
   {
      LCDPC_COM_V3 = 2'h0,
      LCDPC_COM_VREG = 2'h1,
      LCDPC_COM_MV3 = 2'h2
   } lcdpc_com_lvl_t;

   // One command write
   typedef struct packed
   {
      logic wr;
      logic [1:0] sel;
      logic [6:0] data;
   } lcdpc_cmd_t;

   // Enables and settings handed to the analog supply
   typedef struct packed
   {
      logic pump_en;
      logic regulator_en;
      logic level_divider_en;
      logic [1:0] pump_factor;
      logic [6:0] contrast_step;
      logic [1:0] drive_voltage_range;
   } lcdpc_supply_t;
endpackage : lcdpc_pkg

// File: logic/lcdpc_com_scan.sv
// Purpose: Common scan position counter with selectable direction.
// Assumes: line_step and frame_start come from the display timing logic.
// Notes: Position wraps at the end of the scan in either direction.
module lcdpc_com_scan
   import lcdpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic reverse,
   input wire logic frame_start,
   input wire logic line_step,
   output logic [7:0] active_com
);
   logic [7:0] pos_reg; // Current common output being scanned
   logic [7:0] pos_next; // Next scan position

   // Next position: restart at frame, otherwise step up or down
   always_comb
   begin
      pos_next = pos_reg;
      if (frame_start)
      begin
         pos_next = reverse ? LCDPC_COM_LAST : LCDPC_COM_FIRST;
      end
      else if (line_step)
      begin
         if (reverse)
         begin
            pos_next = (pos_reg == LCDPC_COM_FIRST) ? LCDPC_COM_LAST : pos_reg - 8'h01;
         end
         else
         begin
            pos_next = (pos_reg == LCDPC_COM_LAST) ? LCDPC_COM_FIRST : pos_reg + 8'h01;
         end
      end
   end

   // Position register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pos_reg <= 8'h00;
      end
      else
      begin
         pos_reg <= pos_next;
      end
   end

   assign active_com = pos_reg;
endmodule : lcdpc_com_scan

// File: verification/lcdpc_panel.sv
// Purpose: Panel row model fed by the drive outputs.
// Assumes: Drive levels are steady between clock edges.
// Notes: Reports the common level of the row under scan.
module lcdpc_panel
   import lcdpc_pkg::*;
(
   input wire logic [7:0] active_com,
   input wire logic [LCDPC_NCOM-1:0][1:0] common_output,
   output logic [1:0] row_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // Row under scan sees the common level of its own line
   assign row_level = common_output[active_com];
endmodule : lcdpc_panel

// File: verification/testbench.sv
// Purpose: Self-checking bench for the drive and power control block.
// Assumes: Settings reach the block as one-cycle command writes.
// Notes: Host spacing between regulator and divider is not waited out.
module testbench
   import lcdpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0; // Bench clock
   logic rst = 1'b1; // Reset, held at start
   logic master_sel = 1'b1; // Master select pin
   logic frame_start = 1'b0; // Scan restart pulse
   logic line_step = 1'b0; // Scan advance pulse
   lcdpc_cmd_t cmd = '0; // Command write
   logic [LCDPC_NSEG-1:0][2:0] seg_code = '0; // Segment decoder codes
   logic [LCDPC_NCOM-1:0][1:0] com_code = '0; // Common decoder codes
   lcdpc_seg_lvl_t [LCDPC_NSEG-1:0] segment_output;
   lcdpc_com_lvl_t [LCDPC_NCOM-1:0] common_output;
   lcdpc_supply_t supply;
   logic [7:0] active_com;
   logic [1:0] row_level;
   int err_total = 0;
   int tests_run = 0;
   int sup_m = 0; // Model of stored settings
   int con_m = 0;
   int rng_m = 0;
   int rev_m = 0;
   int pos_m = 0;
   // Divider is on before the regulator turns on, so no divider-on follows a regulator-on
   int pats[$] = '{0, 1, 3, 15, 23, 31};

   // Free-running clock
   always #20 clk = ~clk;

   lcdpc_top u_dut (.clk(clk), .rst(rst), .master_sel(master_sel), .cmd(cmd),
      .frame_start(frame_start), .line_step(line_step), .seg_code(seg_code),
      .com_code(com_code), .segment_output(segment_output),
      .common_output(common_output), .supply(supply), .active_com(active_com));
   lcdpc_panel u_panel (.active_com(active_com), .common_output(common_output),
      .row_level(row_level));

   // Compare and count
   task automatic chk(input string what, input logic [479:0] seen, input logic [479:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   // Verdict and end of run
   task automatic wrap_up;
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   // Wait n edges, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   // One command write, model updated alongside
   task automatic put(input int sel, input int data);
      cmd = '{wr: 1'b1, sel: 2'(sel), data: 7'(data)};
      tick(1);
      cmd.wr = 1'b0;
      if (sel == 0) sup_m = data;
      if (sel == 1) con_m = data;
      if (sel == 2) rng_m = data;
      if (sel == 3) rev_m = data;
      tick(1);
   endtask : put

   // Supply struct against the model, enables gated by master
   task automatic chk_sup;
      logic ms;
      ms = master_sel;
      chk("supply", 480'(supply), 480'({ms & sup_m[2], ms & sup_m[1], ms & sup_m[0],
         2'(sup_m >> 3), 7'(con_m), 2'(rng_m)}));
   endtask : chk_sup

   // Random decoder codes, undefined ones included
   task automatic levels;
      logic [LCDPC_NSEG-1:0][2:0] es;
      logic [LCDPC_NCOM-1:0][1:0] ec;
      int j;
      for (int i = 0; i < LCDPC_NSEG; i++)
      begin
         seg_code[i] = 3'($urandom % 8);
         es[i] = (seg_code[i] < 3'h5) ? seg_code[i] : 3'h2;
      end
      for (int k = 0; k < LCDPC_NCOM; k++)
         com_code[k] = 2'($urandom % 4);
      for (int k = 0; k < LCDPC_NCOM; k++)
      begin
         j = (rev_m != 0) ? 131 - k : k;
         ec[k] = (com_code[j] < 2'h3) ? com_code[j] : 2'h1;
      end
      tick(1);
      chk("segment", 480'(segment_output), 480'(es));
      chk("common", 480'(common_output), 480'(ec));
      chk("row", 480'(row_level), 480'(ec[active_com]));
   endtask : levels

   // Restart with a step in the same cycle, then a full lap
   task automatic scan;
      frame_start = 1'b1;
      line_step = 1'b1;
      tick(1);
      frame_start = 1'b0;
      pos_m = (rev_m != 0) ? 131 : 0;
      chk("scan start", 480'(active_com), 480'(pos_m));
      repeat (133)
      begin
         tick(1);
         pos_m = (rev_m != 0) ? (pos_m + 131) % 132 : (pos_m + 1) % 132;
         chk("scan", 480'(active_com), 480'(pos_m));
      end
      line_step = 1'b0;
   endtask : scan

   // Main sequence
   initial
   begin
      void'($urandom(32'h1410));
      tick(12);
      rst = 1'b0;
      tick(1);
      chk_sup();
      foreach (pats[i])
      begin
         put(0, pats[i]);
         chk_sup();
      end
      put(0, 31);
      master_sel = 1'b0;
      tick(3);
      chk_sup();
      put(0, 23);
      chk_sup();
      master_sel = 1'b1;
      tick(3);
      chk_sup();
      for (int i = 0; i < 6; i++)
      begin
         put(1, (i == 0) ? 127 : (i == 1) ? 0 : int'($urandom % 128));
         chk_sup();
      end
      put(2, 2);
      put(2, 3);
      chk_sup();
      put(2, 0);
      chk_sup();
      put(2, 2);
      chk_sup();
      for (int r = 0; r < 2; r++)
      begin
         put(3, r);
         repeat (3) levels();
         scan();
         levels();
      end
      // Second reset in mid-run returns all settings to zero
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      sup_m = 0;
      con_m = 0;
      rng_m = 0;
      rev_m = 0;
      tick(1);
      chk_sup();
      chk("scan reset", 480'(active_com), 480'(0));
      wrap_up();
   end

   // Watchdog against a hang
   initial
   begin
      #(40 * 20000);
      err_total++;
      wrap_up();
   end
endmodule : testbench
